// file: rtl/rre_pkg.sv
// Package: opcodes, flag layout, cycle counts and bus types for the rotate/return unit
package rre_pkg;

    // Opcodes
    localparam logic [7:0] OP_SUBROUTINE_EXIT       = 8'hAF;
    localparam logic [7:0] OP_ROTATE_LEFT_R         = 8'h90;
    localparam logic [7:0] OP_ROTATE_LEFT_IR        = 8'h91;
    localparam logic [7:0] OP_ROTATE_LEFT_VIA_C_R   = 8'h10;
    localparam logic [7:0] OP_ROTATE_LEFT_VIA_C_IR  = 8'h11;
    localparam logic [7:0] OP_ROTATE_RIGHT_R        = 8'hE0;
    localparam logic [7:0] OP_ROTATE_RIGHT_IR       = 8'hE1;
    localparam logic [7:0] OP_ROTATE_RIGHT_VIA_C_R  = 8'hC0;
    localparam logic [7:0] OP_ROTATE_RIGHT_VIA_C_IR = 8'hC1;

    // Flag byte positions
    localparam int FLAG_C = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_S = 1;
    localparam int FLAG_V = 0;

    // Stack step after return
    localparam logic [7:0] SP_RETURN_STEP = 8'h02;

    // Cycle budgets per instruction
    localparam int CYC_SUBROUTINE_EXIT = 10;
    localparam int CYC_ROTATE          = 4;
    localparam logic [3:0] CYC_RET_W   = 4'(CYC_SUBROUTINE_EXIT);
    localparam logic [3:0] CYC_ROT_W   = 4'(CYC_ROTATE);

    // Reset values
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] PC_RST   = 16'h0000;

    typedef enum logic [1:0] {
        ROT_LEFT,
        ROT_LEFT_VIA_C,
        ROT_RIGHT,
        ROT_RIGHT_VIA_C
    } rre_rot_t;

    // Memory read request
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
    } rre_rd_t;

    // Register / memory write request
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } rre_wr_t;

endpackage : rre_pkg

// file: rtl/rre_rotator.sv
// Combinational rotate with flag computation
`timescale 1ns/1ps
`default_nettype none
module rre_rotator (
    // Operation
    input  wire logic             [1:0] op,
    input  wire logic             [7:0] operand,
    input  wire logic                   carryIn,
    // Result
    output logic                  [7:0] result,
    output logic                        carryOut,
    output logic                        zeroOut,
    output logic                        signOut,
    output logic                        overflowOut
);
    import rre_pkg::*;

    always_comb begin
        result   = operand;
        carryOut = carryIn;
        case (rre_rot_t'(op))
            ROT_LEFT: begin
                result   = {operand[6:0], operand[7]};
                carryOut = operand[7];
            end
            ROT_LEFT_VIA_C: begin
                result   = {operand[6:0], carryIn};
                carryOut = operand[7];
            end
            ROT_RIGHT: begin
                result   = {operand[0], operand[7:1]};
                carryOut = operand[0];
            end
            default: begin
                result   = {carryIn, operand[7:1]};
                carryOut = operand[0];
            end
        endcase
        zeroOut     = (result == 8'h00);
        signOut     = result[7];
        overflowOut = result[7] ^ operand[7];
    end

endmodule : rre_rotator
`default_nettype wire

// file: rtl/rre_exec.sv
// Execution unit for subroutine exit and the four one-bit rotates
`timescale 1ns/1ps
`default_nettype none
module rre_exec (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   resetn,
    // Instruction issue
    input  wire logic                   start,
    input  wire logic             [7:0] opcode,
    input  wire logic             [7:0] operandAddr,
    output logic                        busy,
    output logic                        done,
    // Core state
    input  wire logic             [7:0] stackPtr,
    input  wire logic            [15:0] pcIn,
    // Memory / register file read port, data valid while the request stands, then held
    output rre_pkg::rre_rd_t            memRd,
    input  wire logic             [7:0] memRdData,
    // Memory / register file write port
    output rre_pkg::rre_wr_t            memWr,
    // Results to the core
    output logic                  [7:0] flags,
    output logic                  [7:0] spOut,
    output logic                        spLoad,
    output logic                 [15:0] pcOut,
    output logic                        fetchReq,
    output logic                 [15:0] fetchAddr,
    output logic                        illegal
);
    import rre_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE,
        S_PTR,
        S_OPND,
        S_RET_HI,
        S_RET_LO,
        S_WAIT
    } rre_state_t;

    rre_state_t state_r;
    logic [7:0]  op_r;
    logic [7:0]  addr_r;
    logic [7:0]  opnd_r;
    logic [7:0]  pcHi_r;
    logic [3:0]  cyc_r;
    logic [7:0]  rotRes;
    logic        rotC;
    logic        rotZ;
    logic        rotS;
    logic        rotV;

    function automatic logic isRotate(input logic [7:0] o);
        return (o == OP_ROTATE_LEFT_R) || (o == OP_ROTATE_LEFT_IR) ||
               (o == OP_ROTATE_LEFT_VIA_C_R) || (o == OP_ROTATE_LEFT_VIA_C_IR) ||
               (o == OP_ROTATE_RIGHT_R) || (o == OP_ROTATE_RIGHT_IR) ||
               (o == OP_ROTATE_RIGHT_VIA_C_R) || (o == OP_ROTATE_RIGHT_VIA_C_IR);
    endfunction : isRotate

    function automatic logic [1:0] rotKind(input logic [7:0] o);
        logic [1:0] k;
        k = 2'(ROT_RIGHT_VIA_C);
        if (o[7:1] == OP_ROTATE_LEFT_R[7:1])            k = 2'(ROT_LEFT);
        else if (o[7:1] == OP_ROTATE_LEFT_VIA_C_R[7:1]) k = 2'(ROT_LEFT_VIA_C);
        else if (o[7:1] == OP_ROTATE_RIGHT_R[7:1])      k = 2'(ROT_RIGHT);
        return k;
    endfunction : rotKind

    rre_rotator u_rot (
        .op          (rotKind(op_r)),
        .operand     (opnd_r),
        .carryIn     (flags[FLAG_C]),
        .result      (rotRes),
        .carryOut    (rotC),
        .zeroOut     (rotZ),
        .signOut     (rotS),
        .overflowOut (rotV)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_r <= S_IDLE;
            op_r    <= 8'h00;
            addr_r  <= 8'h00;
            opnd_r  <= 8'h00;
            pcHi_r  <= 8'h00;
            cyc_r   <= 4'h0;
        end else begin
            if (cyc_r != 4'h0) begin
                cyc_r <= cyc_r - 4'h1;
            end
            case (state_r)
                S_IDLE: begin
                    if (start && (opcode == OP_SUBROUTINE_EXIT)) begin
                        op_r    <= opcode;
                        addr_r  <= stackPtr;
                        cyc_r   <= CYC_RET_W - 4'h1;
                        state_r <= S_RET_HI;
                    end else if (start && isRotate(opcode)) begin
                        op_r    <= opcode;
                        addr_r  <= operandAddr;
                        cyc_r   <= CYC_ROT_W - 4'h1;
                        // Odd opcode is the indirect form
                        state_r <= opcode[0] ? S_PTR : S_OPND;
                    end
                end
                S_PTR: begin
                    // Pointer value becomes the operand address; pointer itself is never written
                    addr_r  <= memRdData;
                    state_r <= S_OPND;
                end
                S_OPND: begin
                    opnd_r  <= memRdData;
                    state_r <= S_WAIT;
                end
                S_RET_HI: begin
                    pcHi_r  <= memRdData;
                    addr_r  <= addr_r + 8'h01;
                    state_r <= S_WAIT;
                end
                S_WAIT: begin
                    if (cyc_r == 4'h1 || cyc_r == 4'h0) begin
                        state_r <= S_IDLE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read requests, registered so each stands during the state that consumes the data
    always_ff @(posedge clock) begin
        if (!resetn) begin
            memRd <= '0;
        end else begin
            memRd.valid <= 1'b0;
            if (state_r == S_IDLE && start && opcode == OP_SUBROUTINE_EXIT) begin
                memRd <= '{valid: 1'b1, addr: stackPtr};
            end else if (state_r == S_IDLE && start && isRotate(opcode)) begin
                memRd <= '{valid: 1'b1, addr: operandAddr};
            end else if (state_r == S_PTR) begin
                memRd <= '{valid: 1'b1, addr: memRdData};
            end else if (state_r == S_RET_HI) begin
                memRd <= '{valid: 1'b1, addr: addr_r + 8'h01};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Completion: writes, flags, PC and SP
    logic finish;
    assign finish = (state_r == S_WAIT) && (cyc_r <= 4'h1);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            memWr <= '0;
        end else begin
            memWr.valid <= 1'b0;
            if (finish && isRotate(op_r)) begin
                memWr <= '{valid: 1'b1, addr: addr_r, data: rotRes};
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            flags <= FLAGS_RST;
        end else if (finish && isRotate(op_r)) begin
            flags[FLAG_C] <= rotC;
            flags[FLAG_Z] <= rotZ;
            flags[FLAG_S] <= rotS;
            flags[FLAG_V] <= rotV;
        end
        // Return never touches flags
    end

    // Low byte is taken from read data in S_WAIT one cycle after its request ends, so the
    // memory must hold its read data until the answer is consumed.
    logic [7:0] pcLoHold_r;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pcLoHold_r <= 8'h00;
        end else if (state_r == S_WAIT && op_r == OP_SUBROUTINE_EXIT && cyc_r == 4'(CYC_SUBROUTINE_EXIT - 3)) begin
            pcLoHold_r <= memRdData;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pcOut     <= PC_RST;
            spOut     <= 8'h00;
            spLoad    <= 1'b0;
            fetchReq  <= 1'b0;
            fetchAddr <= PC_RST;
            done      <= 1'b0;
            illegal   <= 1'b0;
            busy      <= 1'b0;
        end else begin
            spLoad   <= 1'b0;
            fetchReq <= 1'b0;
            done     <= finish;
            illegal  <= (state_r == S_IDLE) && start && !isRotate(opcode) && (opcode != OP_SUBROUTINE_EXIT);
            busy     <= (state_r != S_IDLE && !finish) ||
                        (state_r == S_IDLE && start && (isRotate(opcode) || opcode == OP_SUBROUTINE_EXIT));
            if (finish && op_r == OP_SUBROUTINE_EXIT) begin
                pcOut     <= {pcHi_r, pcLoHold_r};
                spOut     <= (addr_r - 8'h01) + SP_RETURN_STEP;
                spLoad    <= 1'b1;
                fetchReq  <= 1'b1;
                fetchAddr <= {pcHi_r, pcLoHold_r};
            end else if (finish) begin
                pcOut <= pcIn;
            end
        end
    end

endmodule : rre_exec
`default_nettype wire

// file: verification/rre_exec_props.sv
// Port-level assertions for the rotate/return unit
`timescale 1ns/1ps
`default_nettype none
module rre_exec_props (
    // Clock and reset
    input wire logic             clock,
    input wire logic             resetn,
    // Issue
    input wire logic             start,
    input wire logic [7:0]       opcode,
    input wire logic [7:0]       operandAddr,
    input wire logic             busy,
    input wire logic             done,
    input wire logic [7:0]       stackPtr,
    input wire logic [15:0]      pcIn,
    // Memory
    input wire rre_pkg::rre_rd_t memRd,
    input wire logic [7:0]       memRdData,
    input wire rre_pkg::rre_wr_t memWr,
    // Results
    input wire logic [7:0]       flags,
    input wire logic [7:0]       spOut,
    input wire logic             spLoad,
    input wire logic [15:0]      pcOut,
    input wire logic             fetchReq,
    input wire logic [15:0]      fetchAddr,
    input wire logic             illegal
);
    import rre_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic take;
    logic rotTake;
    logic retTake;
    assign take    = start && (!busy || done);
    assign retTake = take && opcode == OP_SUBROUTINE_EXIT;
    assign rotTake = take && opcode inside {OP_ROTATE_LEFT_R, OP_ROTATE_LEFT_IR, OP_ROTATE_LEFT_VIA_C_R,
        OP_ROTATE_LEFT_VIA_C_IR, OP_ROTATE_RIGHT_R, OP_ROTATE_RIGHT_IR, OP_ROTATE_RIGHT_VIA_C_R,
        OP_ROTATE_RIGHT_VIA_C_IR};
    ////////////////////////////////////////////////////////////
    sequence s_ret_reads;
        memRd.valid && memRd.addr == $past(stackPtr) ##1 memRd.valid && memRd.addr == $past(stackPtr, 2) + 8'h01;
    endsequence
    sequence s_ptr_chase;
        memRd.valid && memRd.addr == $past(operandAddr) ##1 memRd.valid && memRd.addr == $past(memRdData);
    endsequence
    a_rot_cycle_count: assert property (rotTake |-> ##1 !done [*3] ##1 done && memWr.valid)
        else $error("rotate did not finish in four cycles");
    a_ret_stack_reads: assert property (retTake |-> ##1 s_ret_reads ##8 done && spLoad && fetchReq)
        else $error("return stack reads or timing wrong");
    a_ret_sp_step: assert property (retTake |-> ##10 spOut == $past(stackPtr, 10) + SP_RETURN_STEP)
        else $error("return stack pointer step wrong");
    a_ret_flags_kept: assert property (retTake |-> ##10 flags == $past(flags, 10))
        else $error("return changed the flags");
    a_fetch_resume: assert property (fetchReq |-> fetchAddr == pcOut && !memWr.valid)
        else $error("fetch address differs from program counter");
    a_zero_sign: assert property (memWr.valid |-> flags[FLAG_Z] == (memWr.data == 8'h00)
        && flags[FLAG_S] == memWr.data[7])
        else $error("zero or sign flag wrong");
    a_ptr_indirect: assert property (rotTake && opcode[0] |-> ##1 s_ptr_chase ##2 memWr.valid
        && memWr.addr == $past(memRdData, 3))
        else $error("indirect rotate wrote wrong place");
    a_busy_span: assert property (rotTake |=> busy [*3] ##1 !busy && done)
        else $error("busy does not span the rotate");
    a_illegal_pulse: assert property (take && !rotTake && !retTake |=> illegal && !busy && !done)
        else $error("unknown opcode not flagged");
    a_rol_result: assert property (rotTake && opcode == OP_ROTATE_LEFT_R |-> ##4 memWr.data
        == {$past(memRdData[6:0], 2), $past(memRdData[7], 2)} && flags[FLAG_C] == memWr.data[0])
        else $error("rotate left result wrong");
    a_overflow_flag: assert property (rotTake && !opcode[0] |-> ##4 flags[FLAG_V]
        == (memWr.data[7] ^ $past(memRdData[7], 2)))
        else $error("overflow flag wrong");
endmodule : rre_exec_props
bind rre_exec rre_exec_props u_props (.clock(clock), .resetn(resetn), .start(start), .opcode(opcode),
    .operandAddr(operandAddr), .busy(busy), .done(done), .stackPtr(stackPtr), .pcIn(pcIn), .memRd(memRd),
    .memRdData(memRdData), .memWr(memWr), .flags(flags), .spOut(spOut), .spLoad(spLoad), .pcOut(pcOut),
    .fetchReq(fetchReq), .fetchAddr(fetchAddr), .illegal(illegal));
`default_nettype wire

// file: verification/rre_mem_model.sv
// Register file and stack memory model on the unit's far side
`timescale 1ns/1ps
`default_nettype none
module rre_mem_model (
    // Clock
    input  wire logic             clock,
    // Requests
    input  wire rre_pkg::rre_rd_t rd,
    input  wire rre_pkg::rre_wr_t wr,
    // Read data, answers a standing request at once and is held after it
    output logic [7:0]            rdData
);
    import rre_pkg::*;
    logic [7:0] mem [256];
    logic [7:0] heldData_r = 8'h00;
    // Plain always, since the bench preloads mem directly
    always @(posedge clock) begin
        if (rd.valid) heldData_r <= mem[rd.addr];
        if (wr.valid) mem[wr.addr] <= wr.data;
    end
    // The unit takes read data at the edge that ends its request cycle, except the return low byte, taken one edge later
    assign rdData = rd.valid ? mem[rd.addr] : heldData_r;
endmodule : rre_mem_model
`default_nettype wire

// file: verification/test_rotate_and_return_exec.sv
// Self-checking bench for the rotate/return unit
`timescale 1ns/1ps
`default_nettype none
module test_rotate_and_return_exec;
    import rre_pkg::*;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        start = 1'b0;
    logic [7:0]  opcode = 8'h00;
    logic [7:0]  operandAddr = 8'h00;
    logic [7:0]  stackPtr = 8'h00;
    logic [15:0] pcIn = 16'h0000;
    logic [7:0]  memRdData, flags, spOut, expFlags = FLAGS_RST;
    logic        busy, done, spLoad, fetchReq, illegal;
    logic [15:0] pcOut, fetchAddr;
    rre_rd_t     memRd;
    rre_wr_t     memWr;
    logic [31:0] seed = 32'd52718;
    logic [32:0] q [$];
    logic [32:0] e;
    logic [7:0]  img [256];
    int          n_errors = 0;
    int          tests_run = 0;
    localparam logic [7:0] OPS [8] = '{8'h90, 8'h91, 8'h10, 8'h11, 8'hE0, 8'hE1, 8'hC0, 8'hC1};
    always #4 clock = ~clock;
    rre_exec u_dut (.clock(clock), .resetn(resetn), .start(start), .opcode(opcode), .operandAddr(operandAddr),
        .busy(busy), .done(done), .stackPtr(stackPtr), .pcIn(pcIn), .memRd(memRd), .memRdData(memRdData),
        .memWr(memWr), .flags(flags), .spOut(spOut), .spLoad(spLoad), .pcOut(pcOut), .fetchReq(fetchReq),
        .fetchAddr(fetchAddr), .illegal(illegal));
    rre_mem_model u_mem (.clock(clock), .rd(memRd), .wr(memWr), .rdData(memRdData));
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic put(input logic [7:0] a, input logic [7:0] v);
        img[a] = v;
        u_mem.mem[a] = v;
    endtask : put
    task automatic issue(input logic [7:0] op, input logic [7:0] a, input logic [7:0] sp);
        @(posedge clock) begin
            start <= 1'b1;
            opcode <= op;
            operandAddr <= a;
            stackPtr <= sp;
            pcIn <= {rnd(), rnd()};
        end
        @(posedge clock) start <= 1'b0;
        // Bounded wait on completion
        repeat (14) begin
            @(posedge clock);
            if (done === 1'b1) break;
        end
    endtask : issue
    task automatic rotate(input int i);
        logic [7:0] op, a, p, v, r;
        logic c;
        op = OPS[i % 8];
        v = (i == 0) ? 8'h00 : rnd();
        p = rnd() & 8'h7F;
        a = op[0] ? (p | 8'h80) : p;
        if (op[0]) put(p, a);
        put(a, v);
        case (op[7:4])
            4'h9: begin r = {v[6:0], v[7]}; c = v[7]; end
            4'h1: begin r = {v[6:0], expFlags[FLAG_C]}; c = v[7]; end
            4'hE: begin r = {v[0], v[7:1]}; c = v[0]; end
            default: begin r = {expFlags[FLAG_C], v[7:1]}; c = v[0]; end
        endcase
        expFlags = {4'h0, c, r == 8'h00, r[7], r[7] ^ v[7]};
        q.push_back({8'h01, a, r, expFlags});
        img[a] = r;
        issue(op, p, stackPtr);
        #1;
        if (op[0]) check({24'h0, u_mem.mem[p]}, {24'h0, img[p]});
    endtask : rotate
    task automatic ret(input logic [7:0] sp);
        logic [7:0] hi, lo;
        hi = rnd();
        lo = rnd();
        put(sp, hi);
        put(sp + 8'h01, lo);
        q.push_back({1'b1, 8'(sp + SP_RETURN_STEP), expFlags, hi, lo});
        issue(OP_SUBROUTINE_EXIT, rnd(), sp);
    endtask : ret
    // Oldest note is taken at each completion
    always @(posedge clock) begin
        if (resetn && done === 1'b1) begin
            e = q.pop_front();
            if (e[32]) check({spOut, flags, fetchAddr}, e[31:0]);
            else check({7'h00, memWr.valid, memWr.addr, memWr.data, flags}, e[31:0]);
        end
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 24; i++) rotate(i);
        $display("test rotates finished");
        // Unknown opcode: no completion and no queued note
        issue(8'h42, rnd(), stackPtr);
        $display("test unknown opcode finished");
        // Top of address space checks wrap of the second stack byte
        ret(8'hBC);
        ret(8'hFF);
        ret(rnd());
        $display("test returns finished");
        repeat (4) @(posedge clock);
        // A hung instruction leaves its note behind
        check(q.size(), 32'h0);
        final_report();
    end
    initial begin
        repeat (5000) @(posedge clock);
        $display("watchdog expired");
        n_errors++;
        final_report();
    end
endmodule : test_rotate_and_return_exec
`default_nettype wire
